//--- src/rfac_accept_ctrl.sv
// Receive frame acceptance control: register, AXI4-Lite slave and the
// per-frame keep or discard decision.
// Assumes the receive path presents one frame verdict request as a
// single-cycle pulse with its class flags, synchronous to aclk.
`timescale 1ns/100ps
module rfac_accept_ctrl
   import rfac_pkg::*;
(
   // Clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // AXI4-Lite write address
   input  wire logic                   s_axi_awvalid,
   output      logic                   s_axi_awready,
   input  wire logic [RFAC_ADDR_W-1:0] s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic                   s_axi_wvalid,
   output      logic                   s_axi_wready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   // AXI4-Lite write response
   output      logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   output      logic [1:0]             s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                   s_axi_arvalid,
   output      logic                   s_axi_arready,
   input  wire logic [RFAC_ADDR_W-1:0] s_axi_araddr,
   // AXI4-Lite read data
   output      logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output      logic [31:0]            s_axi_rdata,
   output      logic [1:0]             s_axi_rresp,
   // Configuration memory initial load
   input  wire logic                   cfg_load_valid,
   input  wire logic [15:0]            cfg_load_data,
   // Frame verdict request from the receive path
   input  wire logic                   frame_valid,
   input  wire logic                   frame_bad_checksum,
   input  wire logic                   frame_undersized,
   input  wire logic                   frame_oversized,
   input  wire logic                   dest_own_station,
   input  wire logic                   dest_hashed_individual,
   input  wire logic                   dest_group_hashed,
   input  wire logic                   dest_all_ones,
   // Frame verdict
   output      logic                   verdict_valid,
   output      logic                   verdict_keep,
   output      logic                   verdict_discard,
   output      logic                   hashed_individual_event
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [15:0]            accept;
      logic                   aw_have;
      logic [RFAC_ADDR_W-1:0] aw_addr;
      logic                   w_have;
      logic [31:0]            w_data;
      logic [3:0]             w_strb;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
      logic                   v_valid;
      logic                   v_keep;
      logic                   v_hash_ev;
      logic [15:0]            kept_cnt;
      logic [15:0]            drop_cnt;
   } rfac_state_s;

   rfac_state_s s_q;
   rfac_state_s s_d;

   // ****************************************************************
   // Decoding
   // ****************************************************************
   // Byte lanes above the 16-bit register are ignored; the fixed
   // identifier and reserved top bit are never written.
   function automatic logic [15:0] rfac_merge(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
      logic [15:0] m;
      m = {{8{strb[1]}}, {8{strb[0]}}} & RFAC_ACCEPT_WMASK;
      return (old & ~m) | (data[15:0] & m);
   endfunction

   function automatic logic rfac_decode(input logic [RFAC_ADDR_W-1:0] a);
      return (a[RFAC_ADDR_W-1:2] == RFAC_OFS_ACCEPT[RFAC_ADDR_W-1:2])
          || (a[RFAC_ADDR_W-1:2] == RFAC_OFS_COUNTS[RFAC_ADDR_W-1:2]);
   endfunction

   logic addr_pass;
   logic qual_pass;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      s_d = s_q;

      // A frame with an error class is kept only if every error it
      // carries is accepted; a clean frame needs the good-frame bit.
      qual_pass = (frame_bad_checksum || frame_undersized || frame_oversized)
         ? ((!frame_bad_checksum || s_q.accept[RFAC_B_BAD_CHKSUM])
            && (!frame_undersized || s_q.accept[RFAC_B_UNDERSIZED])
            && (!frame_oversized || s_q.accept[RFAC_B_OVERSIZED]))
         : s_q.accept[RFAC_B_GOOD];
      addr_pass = s_q.accept[RFAC_B_ANY_DEST]
         || (dest_own_station && s_q.accept[RFAC_B_OWN_STATION])
         || (dest_hashed_individual && s_q.accept[RFAC_B_HASHED_IND])
         || (dest_group_hashed && s_q.accept[RFAC_B_GROUP_HASH])
         || (dest_all_ones && s_q.accept[RFAC_B_ALL_ONES]);

      s_d.v_valid   = frame_valid;
      if (frame_valid)
      begin
         s_d.v_keep    = addr_pass && qual_pass;
         s_d.v_hash_ev = dest_hashed_individual
                         && s_q.accept[RFAC_B_HASHED_IND];
         if (addr_pass && qual_pass)
         begin
            s_d.kept_cnt = s_q.kept_cnt + 16'h0001;
         end
         else
         begin
            s_d.drop_cnt = s_q.drop_cnt + 16'h0001;
         end
      end

      // Configuration memory contents replace the writable bits.
      if (cfg_load_valid)
      begin
         s_d.accept = (s_q.accept & ~RFAC_ACCEPT_WMASK)
                      | (cfg_load_data & RFAC_ACCEPT_WMASK);
      end

      // Write channel: address and data are taken in either order.
      if (s_axi_awvalid && s_axi_awready)
      begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         s_d.w_have = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
      begin
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = rfac_decode(s_q.aw_addr) ? RFAC_RESP_OKAY : RFAC_RESP_SLVERR;
         // A software write wins over a simultaneous memory load.
         if (s_q.aw_addr[RFAC_ADDR_W-1:2] == RFAC_OFS_ACCEPT[RFAC_ADDR_W-1:2])
         begin
            s_d.accept = rfac_merge(s_q.accept, s_q.w_data, s_q.w_strb);
         end
      end
      if (s_q.bvalid && s_axi_bready)
      begin
         s_d.bvalid = 1'b0;
      end

      // Read channel: one cycle from address to data.
      if (s_axi_arvalid && s_axi_arready)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = rfac_decode(s_axi_araddr) ? RFAC_RESP_OKAY : RFAC_RESP_SLVERR;
         if (s_axi_araddr[RFAC_ADDR_W-1:2] == RFAC_OFS_ACCEPT[RFAC_ADDR_W-1:2])
         begin
            s_d.rdata = {16'h0000, s_q.accept};
         end
         else if (s_axi_araddr[RFAC_ADDR_W-1:2] == RFAC_OFS_COUNTS[RFAC_ADDR_W-1:2])
         begin
            s_d.rdata = {s_q.drop_cnt, s_q.kept_cnt};
         end
         else
         begin
            s_d.rdata = 32'h0000_0000;
         end
      end
      else if (s_q.rvalid && s_axi_rready)
      begin
         s_d.rvalid = 1'b0;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q        <= '0;
         s_q.accept <= RFAC_ACCEPT_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign s_axi_awready          = !s_q.aw_have;
   assign s_axi_wready           = !s_q.w_have;
   assign s_axi_bvalid           = s_q.bvalid;
   assign s_axi_bresp            = s_q.bresp;
   assign s_axi_arready          = !s_q.rvalid;
   assign s_axi_rvalid           = s_q.rvalid;
   assign s_axi_rdata            = s_q.rdata;
   assign s_axi_rresp            = s_q.rresp;
   assign verdict_valid          = s_q.v_valid;
   assign verdict_keep           = s_q.v_valid && s_q.v_keep;
   assign verdict_discard        = s_q.v_valid && !s_q.v_keep;
   assign hashed_individual_event = s_q.v_valid && s_q.v_hash_ev;

endmodule

//--- src/rfac_pkg.sv
// Constants shared by the receive frame acceptance control block.
// Assumes a 32-bit AXI4-Lite register bus and a 12-bit byte address.
package rfac_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int          RFAC_ADDR_W        = 12;
   localparam logic [11:0] RFAC_OFS_ACCEPT    = 12'h104;
   localparam logic [11:0] RFAC_OFS_COUNTS    = 12'h108;

   // ****************************************************************
   // Acceptance control fields
   // ****************************************************************
   localparam logic [15:0] RFAC_ACCEPT_RESET  = 16'h0005;
   localparam logic [15:0] RFAC_ACCEPT_WMASK  = 16'h7FC0;
   localparam logic [5:0]  RFAC_ACCEPT_IDENT  = 6'h05;
   localparam int          RFAC_B_HASHED_IND  = 6;
   localparam int          RFAC_B_ANY_DEST    = 7;
   localparam int          RFAC_B_GOOD        = 8;
   localparam int          RFAC_B_GROUP_HASH  = 9;
   localparam int          RFAC_B_OWN_STATION = 10;
   localparam int          RFAC_B_ALL_ONES    = 11;
   localparam int          RFAC_B_BAD_CHKSUM  = 12;
   localparam int          RFAC_B_UNDERSIZED  = 13;
   localparam int          RFAC_B_OVERSIZED   = 14;

   // ****************************************************************
   // Bus responses
   // ****************************************************************
   localparam logic [1:0]  RFAC_RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RFAC_RESP_SLVERR   = 2'h2;

endpackage

//--- tb/rfac_rx_model.sv
// Receive path model: turns a bench request into a one-cycle frame pulse.
// Assumes the bench drives req and flags_in just after a rising edge.
`timescale 1ns/100ps
module rfac_rx_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       req,
   input  wire logic [6:0] flags_in,
   output      logic       frame_valid,
   output      logic [6:0] flags
);
   // Idle flags toggle so that no verdict may lean on stale class flags.
   always_ff @(posedge aclk)
   begin
      frame_valid <= req && aresetn;
      flags       <= !aresetn ? 7'h00 : (req ? flags_in : ~flags);
   end
endmodule

//--- tb/rfac_checker.sv
// Port checker for the acceptance control block.
// Assumes it is bound to rfac_accept_ctrl and sees only its ports.
`timescale 1ns/100ps
module rfac_checker
   import rfac_pkg::*;
(
   input wire logic                   aclk, aresetn, s_axi_arvalid, s_axi_arready,
   input wire logic                   s_axi_rvalid, s_axi_rready, s_axi_bvalid, s_axi_bready,
   input wire logic [RFAC_ADDR_W-1:0] s_axi_araddr,
   input wire logic [31:0]            s_axi_rdata,
   input wire logic [1:0]             s_axi_rresp,
   input wire logic                   frame_valid, dest_hashed_individual, verdict_valid,
   input wire logic                   verdict_keep, verdict_discard, hashed_individual_event
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   verdict_follow_a: assert property (frame_valid |=> verdict_valid)
      else $error("verdict missing");
   verdict_only_a: assert property (!frame_valid |=>
      !verdict_valid && !verdict_keep && !verdict_discard) else $error("stray verdict");
   verdict_one_a: assert property (verdict_valid |-> verdict_keep ^ verdict_discard)
      else $error("keep and discard clash");
   hash_event_a: assert property (hashed_individual_event |->
      verdict_valid && $past(dest_hashed_individual)) else $error("bad hash event");
   ident_read_a: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == RFAC_OFS_ACCEPT |=> s_axi_rvalid && s_axi_rdata[5:0] == RFAC_ACCEPT_IDENT
      && s_axi_rdata[31:15] == 17'h00000) else $error("identifier wrong");
   unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[11:2] != RFAC_OFS_ACCEPT[11:2]
      && s_axi_araddr[11:2] != RFAC_OFS_COUNTS[11:2] |=>
      s_axi_rresp == RFAC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response stuck");
endmodule
bind rfac_accept_ctrl rfac_checker rfac_checker_i (.aclk, .aresetn, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_rdata, .s_axi_rresp, .frame_valid, .dest_hashed_individual, .verdict_valid,
   .verdict_keep, .verdict_discard, .hashed_individual_event);

//--- tb/testbench.sv
// Self-checking bench: register bus, configuration load and frame verdicts.
// Assumes the receive path model drives the frame request port.
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
   import rfac_pkg::*;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, cfg_load_valid = 0, req = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, frame_valid;
   logic verdict_valid, verdict_keep, verdict_discard, hashed_individual_event;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0] cfg_load_data = 0, regv;
   logic [6:0]  fin = 0, fl;
   logic [31:0] rd;
   int          num_errors = 0, compares = 0, i, k;
   int          kept = 0, dropped = 0;
   always #2.5 aclk = ~aclk;
   rfac_rx_model rfac_rx_model_i (.aclk, .aresetn, .req, .flags_in(fin), .frame_valid,
      .flags(fl));
   rfac_accept_ctrl rfac_accept_ctrl_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cfg_load_valid,
      .cfg_load_data, .frame_valid, .frame_bad_checksum(fl[6]), .frame_undersized(fl[5]),
      .frame_oversized(fl[4]), .dest_own_station(fl[3]), .dest_hashed_individual(fl[2]),
      .dest_group_hashed(fl[1]), .dest_all_ones(fl[0]), .verdict_valid, .verdict_keep,
      .verdict_discard, .hashed_individual_event);
   function automatic logic keep_f(logic [15:0] r, logic [6:0] f);
      logic ap;
      ap = r[7] | (f[3] & r[10]) | (f[2] & r[6]) | (f[1] & r[9]) | (f[0] & r[11]);
      if (|f[6:4])
         return ap & (!f[6] | r[12]) & (!f[5] | r[13]) & (!f[4] | r[14]);
      return ap & r[8];
   endfunction
   task automatic tally_and_finish();
      if (num_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic hang();
      num_errors++;
      tally_and_finish();
   endtask
   task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_awvalid <= 1; s_axi_awaddr <= a; s_axi_wvalid <= 1;
      s_axi_wdata <= d; s_axi_wstrb <= 4'hF; s_axi_bready <= 1;
      for (n = 0; n < 50 && !s_axi_bvalid; n++)
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end
      if (n == 50) hang();
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_arvalid <= 1; s_axi_araddr <= a;
      // Late rready keeps the read answer standing for a cycle.
      for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++)
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) s_axi_rready <= 1;
      end
      if (n == 50) hang();
      d = s_axi_rdata; r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   initial
   begin
      void'($urandom(32'h14d9bb97));
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      axr(RFAC_OFS_ACCEPT, rd, rsp);
      `CHK("reset value", 32'h00000005, rd)
      axw(12'h10C, 32'hFFFFFFFF, rsp);
      `CHK("unmapped bresp", RFAC_RESP_SLVERR, rsp)
      axr(12'h10C, rd, rsp);
      `CHK("unmapped rresp", RFAC_RESP_SLVERR, rsp)
      for (i = 0; i < 24; i++)
      begin
         regv = i < 2 ? (i ? 16'h0080 : 16'hFFFF) : 16'($urandom);
         axw(RFAC_OFS_ACCEPT, {16'h0, regv}, rsp);
         `CHK("accept bresp", RFAC_RESP_OKAY, rsp)
         regv = (regv & RFAC_ACCEPT_WMASK) | RFAC_ACCEPT_RESET;
         axr(RFAC_OFS_ACCEPT, rd, rsp);
         `CHK("accept reg", {16'h0, regv}, rd)
         for (k = 0; k < 8; k++)
         begin
            @(posedge aclk);
            req <= 1; fin <= (i == 1 && k == 0) ? 7'h00 : 7'($urandom);
            @(posedge aclk);
            req <= 0;
            @(posedge aclk);
            #1;
            `CHK("keep", keep_f(regv, fin), verdict_keep)
            `CHK("discard", !keep_f(regv, fin), verdict_discard)
            `CHK("hash event", fin[2] & regv[6], hashed_individual_event)
            if (keep_f(regv, fin))
               kept++;
            else
               dropped++;
         end
      end
      @(posedge aclk);
      cfg_load_valid <= 1; cfg_load_data <= 16'($urandom);
      @(posedge aclk);
      cfg_load_valid <= 0;
      axr(RFAC_OFS_ACCEPT, rd, rsp);
      `CHK("cfg load", {16'h0, (cfg_load_data & 16'h7FC0) | 16'h0005}, rd)
      // Software reads both kept and discarded frame counts from the count word.
      axr(RFAC_OFS_COUNTS, rd, rsp);
      `CHK("counts rresp", RFAC_RESP_OKAY, rsp)
      `CHK("frame counts", {16'(dropped), 16'(kept)}, rd)
      tally_and_finish();
   end
endmodule
